// file: pkg/gcs_pkg.sv
// Purpose: Shared constants and code arithmetic for the gold code spreader pair.
// Assumes: Stage n of a code register is bit n-1; stage 10 is the register output.
// Notes: Both ends call the same step and tap functions so their codes agree.
//
// Overview of operation
// - Transmitted chip is code xor data bit.
// - Chips at 1.023 Mbps, data at 50 bps.
// - Receiver regenerates, aligns and strips the code.
// - Code is first xor delayed second sequence.
// - Two ten-stage registers with given polynomials.
// - Both registers start each period all ones.
// - Both registers shift once per chip.
// - Delay made by xor of two stages.
// - Equivalent delay is 5 to 950 chips.
// - Tap pair chosen per code number.
// - First ten chips: leading one, three octal.
// - Codes 34 and 37 share taps.
// - Satellite never sends codes 33 to 37.
// - Payload fault switches to protective nonstandard code.
// - Chip and data timing share one source.
// - Chip clock is standard divided by ten.
package gcs_pkg;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int STD_FREQ_HZ = 10230000;
  localparam int CHIP_RATE_HZ = 1023000;
  localparam int DATA_RATE_BPS = 50;
  localparam int CODE_LEN = 1023;
  localparam int STD_DIV = STD_FREQ_HZ / CHIP_RATE_HZ;
  localparam int PERIODS_PER_BIT = CHIP_RATE_HZ / (CODE_LEN * DATA_RATE_BPS);
  localparam int REG_W = 10;
  localparam logic [REG_W-1:0] REG_INIT = 10'h3FF;
  localparam logic [9:0] LAST_CHIP = 10'h3FE;
  localparam logic [5:0] CODE_FIRST_SAT = 6'h01;
  localparam logic [5:0] CODE_LAST_SAT = 6'h20;
  localparam logic [5:0] CODE_LAST = 6'h25;

  // ----------------------------------------------------------------
  // Link word and transmitter modes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic chip;
    logic code_start;
    logic bit_start;
  } gcs_word_t;

  typedef enum logic [1:0] {
    MODE_STD = 2'b01,
    MODE_PROT = 2'b10
  } gcs_mode_t;

  // ----------------------------------------------------------------
  // Code arithmetic
  // ----------------------------------------------------------------
  // First register, X^10+X^3+1, feedback into stage 1.
  function automatic logic [REG_W-1:0] first_step(input logic [REG_W-1:0] s);
    first_step = {s[8:0], s[2] ^ s[9]};
  endfunction : first_step

  // Second register, X^10+X^9+X^8+X^6+X^3+X^2+1.
  function automatic logic [REG_W-1:0] second_step(input logic [REG_W-1:0] s);
    second_step = {s[8:0], s[1] ^ s[2] ^ s[5] ^ s[7] ^ s[8] ^ s[9]};
  endfunction : second_step

  // Tap stages {a,b}, numbered 1..10, for each code number.
  function automatic logic [7:0] tap_pair(input logic [5:0] code);
    unique case (code)
      6'h01: tap_pair = 8'h26;
      6'h02: tap_pair = 8'h37;
      6'h03: tap_pair = 8'h48;
      6'h04: tap_pair = 8'h59;
      6'h05: tap_pair = 8'h19;
      6'h06: tap_pair = 8'h2A;
      6'h07: tap_pair = 8'h18;
      6'h08: tap_pair = 8'h29;
      6'h09: tap_pair = 8'h3A;
      6'h0A: tap_pair = 8'h23;
      6'h0B: tap_pair = 8'h34;
      6'h0C: tap_pair = 8'h56;
      6'h0D: tap_pair = 8'h67;
      6'h0E: tap_pair = 8'h78;
      6'h0F: tap_pair = 8'h89;
      6'h10: tap_pair = 8'h9A;
      6'h11: tap_pair = 8'h14;
      6'h12: tap_pair = 8'h25;
      6'h13: tap_pair = 8'h36;
      6'h14: tap_pair = 8'h47;
      6'h15: tap_pair = 8'h58;
      6'h16: tap_pair = 8'h69;
      6'h17: tap_pair = 8'h13;
      6'h18: tap_pair = 8'h46;
      6'h19: tap_pair = 8'h57;
      6'h1A: tap_pair = 8'h68;
      6'h1B: tap_pair = 8'h79;
      6'h1C: tap_pair = 8'h8A;
      6'h1D: tap_pair = 8'h16;
      6'h1E: tap_pair = 8'h27;
      6'h1F: tap_pair = 8'h38;
      6'h20: tap_pair = 8'h49;
      6'h21: tap_pair = 8'h5A;
      6'h22: tap_pair = 8'h4A;
      6'h23: tap_pair = 8'h17;
      6'h24: tap_pair = 8'h28;
      6'h25: tap_pair = 8'h4A;
      default: tap_pair = 8'h26;
    endcase
  endfunction : tap_pair

  // Delayed second sequence from two stages, then the code chip.
  function automatic logic code_chip(input logic [REG_W-1:0] fst,
                                     input logic [REG_W-1:0] snd,
                                     input logic [5:0] code);
    logic [7:0] tp;
    logic [3:0] ta;
    logic [3:0] tb;
    tp = tap_pair(code);
    ta = tp[7:4] - 4'h1;
    tb = tp[3:0] - 4'h1;
    code_chip = fst[REG_W-1] ^ snd[ta] ^ snd[tb];
  endfunction : code_chip

endpackage : gcs_pkg

// file: pkg/gcs_link_if.sv
// Purpose: Chip stream link between the spreader and the replica receiver.
// Assumes: One clock shared by both ends.
// Notes: A word moves on a cycle where valid and ready are both high.
`timescale 1ns/1ns
interface gcs_link_if;
  logic chip_valid;
  logic chip_ready;
  gcs_pkg::gcs_word_t word;

  modport tx (output chip_valid, output word, input chip_ready);
  modport rx (input chip_valid, input word, output chip_ready);
endinterface : gcs_link_if

// file: verilog/gcs_transmitter.sv
// Purpose: Gold code generator and data spreader feeding the chip link.
// Assumes: std_tick pulses once per cycle of the 10.23 MHz standard.
// Notes: The generator stalls while the output buffer is full.
`timescale 1ns/1ns
module gcs_transmitter #(
  parameter int DIV = gcs_pkg::STD_DIV,
  parameter int PERIODS = gcs_pkg::PERIODS_PER_BIT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic std_tick,
  input wire logic [5:0] code_num,
  input wire logic payload_fault,
  input wire logic nav_data_bit,
  output logic nav_data_take,
  output logic prot_active,
  gcs_link_if.tx link
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (DIV < 2 || DIV > 255) begin : g_bad_div
      $error("DIV must lie in 2..255");
    end
    if (PERIODS < 1 || PERIODS > 255) begin : g_bad_periods
      $error("PERIODS must lie in 1..255");
    end
  endgenerate

  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam logic [7:0] PER_LAST = 8'(PERIODS - 1);

  // ----------------------------------------------------------------
  // Chip strobe from the frequency standard
  // ----------------------------------------------------------------
  logic [7:0] div_cnt_r;
  logic [7:0] div_cnt_nxt;
  logic pend_r;
  logic pend_nxt;
  wire div_wrap = std_tick && (div_cnt_r == DIV_LAST);
  wire gen_fire;

  // Both chip and data timing count the one standard tick.
  assign div_cnt_nxt = !std_tick ? div_cnt_r :
                       (div_wrap ? 8'h00 : div_cnt_r + 8'h01);
  // A strobe that lands while the previous one is consumed is kept.
  assign pend_nxt = div_wrap | (pend_r & ~gen_fire);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt_r <= 8'h00;
      pend_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Code registers and period counters
  // ----------------------------------------------------------------
  logic [gcs_pkg::REG_W-1:0] fst_r;
  logic [gcs_pkg::REG_W-1:0] snd_r;
  logic [gcs_pkg::REG_W-1:0] fst_nxt;
  logic [gcs_pkg::REG_W-1:0] snd_nxt;
  logic [9:0] chip_idx_r;
  logic [9:0] chip_idx_nxt;
  logic [7:0] per_cnt_r;
  logic [7:0] per_cnt_nxt;
  logic [5:0] code_r;
  logic data_r;
  gcs_pkg::gcs_mode_t mode_r;
  gcs_pkg::gcs_mode_t mode_nxt;

  wire period_end = chip_idx_r == gcs_pkg::LAST_CHIP;
  wire code_start = chip_idx_r == 10'h000;
  wire bit_start = code_start && (per_cnt_r == 8'h00);

  // Selection is sampled only at a period start so a code never splices.
  wire code_ok = (code_num >= gcs_pkg::CODE_FIRST_SAT) && (code_num <= gcs_pkg::CODE_LAST_SAT);
  wire take_sel = gen_fire && code_start;

  assign fst_nxt = period_end ? gcs_pkg::REG_INIT : gcs_pkg::first_step(fst_r);
  assign snd_nxt = period_end ? gcs_pkg::REG_INIT : gcs_pkg::second_step(snd_r);
  assign chip_idx_nxt = period_end ? 10'h000 : chip_idx_r + 10'h001;
  assign per_cnt_nxt = !period_end ? per_cnt_r :
                       (per_cnt_r == PER_LAST ? 8'h00 : per_cnt_r + 8'h01);

  // Fault or a reserved code number both force the protective code.
  assign mode_nxt = (payload_fault || !code_ok) ? gcs_pkg::MODE_PROT
                                                : gcs_pkg::MODE_STD;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fst_r <= gcs_pkg::REG_INIT;
      snd_r <= gcs_pkg::REG_INIT;
      chip_idx_r <= 10'h000;
      per_cnt_r <= 8'h00;
    end else if (gen_fire) begin
      fst_r <= fst_nxt;
      snd_r <= snd_nxt;
      chip_idx_r <= chip_idx_nxt;
      per_cnt_r <= per_cnt_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      code_r <= gcs_pkg::CODE_FIRST_SAT;
      mode_r <= gcs_pkg::MODE_PROT;
    end else if (take_sel) begin
      code_r <= code_num;
      mode_r <= mode_nxt;
    end else if (payload_fault) begin
      mode_r <= gcs_pkg::MODE_PROT;
    end
  end

  // ----------------------------------------------------------------
  // Data bit and composite chip
  // ----------------------------------------------------------------
  // A new data bit is fetched only on the first chip of a bit span.
  wire take_bit = gen_fire && bit_start;
  wire cur_data = bit_start ? nav_data_bit : data_r;
  wire gold = gcs_pkg::code_chip(fst_r, snd_r, code_r);
  // Protective content is deliberately not a valid code of the family.
  wire prot = fst_r[gcs_pkg::REG_W-1] ^ ~snd_r[gcs_pkg::REG_W-1];
  wire spread_chip;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_r <= 1'b0;
      nav_data_take <= 1'b0;
    end else begin
      nav_data_take <= take_bit;
      if (take_bit) begin
        data_r <= nav_data_bit;
      end
    end
  end

  // The first chip of a period already uses the newly selected mode.
  wire use_prot = code_start ? (mode_nxt == gcs_pkg::MODE_PROT) : (mode_r == gcs_pkg::MODE_PROT);
  wire sel_gold = code_start ? gcs_pkg::code_chip(fst_r, snd_r, code_num) : gold;
  assign spread_chip = (use_prot ? prot : sel_gold) ^ cur_data;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prot_active <= 1'b1;
    end else begin
      prot_active <= mode_r == gcs_pkg::MODE_PROT;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry output buffer
  // ----------------------------------------------------------------
  gcs_pkg::gcs_word_t head_r;
  gcs_pkg::gcs_word_t tail_r;
  gcs_pkg::gcs_word_t new_word;
  logic head_v_r;
  logic tail_v_r;

  assign new_word = '{chip: spread_chip, code_start: code_start, bit_start: bit_start};
  wire buf_room = !tail_v_r;
  wire pop = head_v_r && link.chip_ready;
  // A stalled receiver fills the buffer, then holds the generator.
  assign gen_fire = pend_r && buf_room;

  assign link.chip_valid = head_v_r;
  assign link.word = head_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
      head_r <= '0;
      tail_r <= '0;
    end else if (pop && tail_v_r) begin
      head_r <= tail_r;
      tail_v_r <= 1'b0;
    end else if (pop || !head_v_r) begin
      head_v_r <= gen_fire;
      if (gen_fire) begin
        head_r <= new_word;
      end
    end else if (gen_fire) begin
      tail_r <= new_word;
      tail_v_r <= 1'b1;
    end
  end

endmodule : gcs_transmitter

// file: verilog/gcs_receiver.sv
// Purpose: Replica code generator that strips the code and recovers data bits.
// Assumes: The link marks each code period start and each data bit start.
// Notes: A bit is decided by majority over all chips of its span.
`timescale 1ns/1ns
module gcs_receiver #(
  parameter int PERIODS = gcs_pkg::PERIODS_PER_BIT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] code_num,
  input wire logic rx_stall,
  output logic data_bit,
  output logic data_valid,
  output logic locked,
  gcs_link_if.rx link
);

  generate
    if (PERIODS < 1 || PERIODS > 32) begin : g_bad_periods
      $error("PERIODS must lie in 1..32");
    end
  endgenerate

  localparam logic [15:0] HALF = 16'(gcs_pkg::CODE_LEN * PERIODS / 2);

  // ----------------------------------------------------------------
  // Replica generator
  // ----------------------------------------------------------------
  logic [gcs_pkg::REG_W-1:0] fst_r;
  logic [gcs_pkg::REG_W-1:0] snd_r;
  logic [5:0] code_r;
  logic [15:0] acc_r;
  logic [15:0] acc_nxt;

  assign link.chip_ready = !rx_stall;
  wire take = link.chip_valid && !rx_stall;
  wire first = link.word.code_start;

  // Alignment: a marked chip restarts the replica from all ones.
  wire [gcs_pkg::REG_W-1:0] fst_cur = first ? gcs_pkg::REG_INIT : fst_r;
  wire [gcs_pkg::REG_W-1:0] snd_cur = first ? gcs_pkg::REG_INIT : snd_r;
  wire [5:0] code_cur = first ? code_num : code_r;
  wire replica = gcs_pkg::code_chip(fst_cur, snd_cur, code_cur);
  wire stripped = link.word.chip ^ replica;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fst_r <= gcs_pkg::REG_INIT;
      snd_r <= gcs_pkg::REG_INIT;
      code_r <= gcs_pkg::CODE_FIRST_SAT;
    end else if (take) begin
      fst_r <= gcs_pkg::first_step(fst_cur);
      snd_r <= gcs_pkg::second_step(snd_cur);
      code_r <= code_cur;
    end
  end

  // ----------------------------------------------------------------
  // Bit decision
  // ----------------------------------------------------------------
  wire bit_edge = take && link.word.bit_start;
  assign acc_nxt = bit_edge ? {15'h0000, stripped} : acc_r + {15'h0000, stripped};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_r <= 16'h0000;
      locked <= 1'b0;
      data_bit <= 1'b0;
      data_valid <= 1'b0;
    end else begin
      data_valid <= bit_edge && locked;
      if (take) begin
        acc_r <= acc_nxt;
      end
      if (bit_edge) begin
        locked <= 1'b1;
        data_bit <= acc_r > HALF;
      end
    end
  end

endmodule : gcs_receiver

// file: bench/gcs_link_properties.sv
// Purpose: Timing checks on the chip link between the spreader and the receiver.
// Assumes: One clock domain; rst is synchronous and active high.
// Notes: Code contents are judged by the bench, framing and flow control here.
`timescale 1ns/1ns
module gcs_link_properties #(
  parameter int PERIODS = gcs_pkg::PERIODS_PER_BIT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_valid,
  input wire logic chip_ready,
  input wire gcs_pkg::gcs_word_t word
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic take;
  logic [9:0] cnt_r;
  int pcnt_r;
  logic seen_r;
  logic first_r;
  assign take = chip_valid && chip_ready;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 10'h000;
      pcnt_r <= 0;
      seen_r <= 1'b0;
      first_r <= 1'b1;
    end else if (take) begin
      first_r <= 1'b0;
      cnt_r <= word.code_start ? 10'h000 : cnt_r + 10'h001;
      seen_r <= seen_r | word.code_start;
      if (word.code_start) begin
        pcnt_r <= word.bit_start ? 0 : pcnt_r + 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_parked;
    chip_valid && !chip_ready [*2];
  endsequence

  chk_hold_word: assert property (chip_valid && !chip_ready |=> chip_valid && $stable(word))
    else $error("link word changed while parked");
  chk_chip_kept: assert property (chip_valid && $past(chip_valid && !chip_ready)
    |-> word.chip == $past(word.chip)) else $error("parked chip lost");
  chk_ready_resume: assert property (s_parked ##1 chip_ready |-> chip_valid)
    else $error("parked word dropped before ready");
  chk_code_length: assert property (take && seen_r |-> word.code_start == (cnt_r == 10'h3FE))
    else $error("code period not 1023 chips");
  chk_bit_span: assert property (take && word.code_start && seen_r
    |-> word.bit_start == (pcnt_r == PERIODS - 1)) else $error("data span length wrong");
  chk_bit_on_code: assert property (chip_valid && word.bit_start |-> word.code_start)
    else $error("data bit edge off a code boundary");
  chk_first_word: assert property (chip_valid && first_r |-> word.code_start && word.bit_start)
    else $error("first word after reset not a period start");
  chk_reset_idle: assert property (disable iff (1'b0) rst |=> !chip_valid && word == '0)
    else $error("link not idle in reset");
  cover property (take && word.bit_start);
endmodule : gcs_link_properties

// file: bench/tb.sv
// Purpose: Self-checking bench joining the spreader and the replica receiver.
// Assumes: DIV 2 and PERIODS 1 shorten the chip and data spans.
// Notes: Chips are checked against a bench model of both code registers.
`timescale 1ns/1ns
module tb;
  localparam int DIV = 2;
  localparam int PERIODS = 1;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic std_tick = 1'b0;
  logic [5:0] code_num = 6'h01;
  logic [5:0] rx_code = 6'h01;
  logic payload_fault = 1'b0;
  logic nav_data_bit = 1'b0;
  logic rx_stall = 1'b0;
  logic nav_data_take, prot_active, data_bit, data_valid, locked;
  int n_fail = 0;
  int checks_done = 0;
  int idx = 0;
  int n_diff = 0;
  logic [9:0] fst, snd, ten;
  logic [7:0] tp;
  logic [5:0] cur_code, pend_code = 6'h01;
  logic cur_bit, pend_bit = 1'b0, pend_prot = 1'b0, exp_prot, span_prot = 1'b0, ex, started = 1'b0;
  logic [1:0] rq[$];
  logic [1:0] e;
  logic [5:0] codes [6] = '{6'h01, 6'h03, 6'h07, 6'h10, 6'h17, 6'h20};

  gcs_link_if link_a ();
  gcs_transmitter #(.DIV(DIV), .PERIODS(PERIODS)) i_gcs_transmitter (.core_clk(core_clk),
    .rst(rst), .std_tick(std_tick), .code_num(code_num), .payload_fault(payload_fault),
    .nav_data_bit(nav_data_bit), .nav_data_take(nav_data_take), .prot_active(prot_active),
    .link(link_a));
  gcs_receiver #(.PERIODS(PERIODS)) i_gcs_receiver (.core_clk(core_clk), .rst(rst),
    .code_num(rx_code), .rx_stall(rx_stall), .data_bit(data_bit), .data_valid(data_valid),
    .locked(locked), .link(link_a));
  gcs_link_properties #(.PERIODS(PERIODS)) i_gcs_link_properties (.core_clk(core_clk),
    .rst(rst), .chip_valid(link_a.chip_valid), .chip_ready(link_a.chip_ready),
    .word(link_a.word));

  always #10 core_clk = ~core_clk;
  // The standard tick runs faster than life so that whole spans stay short.
  always @(posedge core_clk) std_tick <= ~std_tick;

  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_vec(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_vec

  task automatic end_sim();
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic wait_take();
    int n;
    n = 0;
    @(posedge core_clk);
    while (nav_data_take !== 1'b1 && n < 20000) begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 20000) begin
      n_fail++;
      end_sim();
    end
  endtask : wait_take

  // A new code and data bit take effect from the next span start.
  task automatic next_span(input logic [5:0] code, input logic bit_v);
    wait_take();
    code_num <= code;
    nav_data_bit <= bit_v;
  endtask : next_span

  function automatic logic [7:0] ref_taps(input logic [5:0] c);
    case (c)
      6'h03: ref_taps = 8'h48;
      6'h07: ref_taps = 8'h18;
      6'h10: ref_taps = 8'h9A;
      6'h17: ref_taps = 8'h13;
      6'h20: ref_taps = 8'h49;
      default: ref_taps = 8'h26;
    endcase
  endfunction : ref_taps

  // ----------------------------------------------------------------
  // Link and output monitor
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    // The selection is followed until a period start waits on the link, so that the
    // model and the receiver hold what the spreader sampled for that period. This
    // assumes no stall holds the period start behind an older chip in the buffer.
    if (!(link_a.chip_valid === 1'b1 && link_a.word.code_start === 1'b1)) begin
      pend_code <= code_num;
      pend_bit <= nav_data_bit;
      pend_prot <= payload_fault || code_num < 6'h01 || code_num > 6'h20;
      rx_code <= code_num;
    end
    if (payload_fault || prot_active === 1'b1) span_prot = 1'b1;
    if (!rst && link_a.chip_valid === 1'b1 && link_a.chip_ready === 1'b1) begin
      if (link_a.word.code_start === 1'b1) begin
        if (started && link_a.word.bit_start === 1'b1) rq.push_back({!span_prot, cur_bit});
        span_prot = pend_prot;
        started = 1'b1;
        fst = 10'h3FF;
        snd = 10'h3FF;
        idx = 0;
        cur_code = pend_code;
        cur_bit = pend_bit;
        exp_prot = pend_prot;
      end
      if (started) begin
        tp = ref_taps(cur_code);
        ex = fst[9] ^ snd[tp[7:4] - 4'h1] ^ snd[tp[3:0] - 4'h1] ^ cur_bit;
        if (!(exp_prot | prot_active | payload_fault)) begin
          cmp_bit("chip", ex, link_a.word.chip);
        end else if (link_a.word.chip !== ex) n_diff++;
        cmp_bit("code_start", idx == 0, link_a.word.code_start);
        cmp_bit("bit_start", idx == 0, link_a.word.bit_start);
        if (idx < 10) ten = {ten[8:0], link_a.word.chip ^ cur_bit};
        if (idx == 9 && cur_code == 6'h01 && !exp_prot) cmp_vec("first chips", 10'h320, ten);
        fst = {fst[8:0], fst[2] ^ fst[9]};
        snd = {snd[8:0], snd[1] ^ snd[2] ^ snd[5] ^ snd[7] ^ snd[8] ^ snd[9]};
        idx = (idx == 1022) ? 0 : idx + 1;
      end
    end
    if (!rst && data_valid === 1'b1) begin
      if (rq.size() == 0) begin
        cmp_bit("data_valid", 1'b0, 1'b1);
      end else begin
        e = rq.pop_front();
        cmp_bit("locked", 1'b1, locked);
        if (e[1]) cmp_bit("data_bit", e[0], data_bit);
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) next_span(codes[i], i[0]);
    next_span(6'h01, 1'b1);
    repeat (300) @(posedge core_clk);
    rx_stall <= 1'b1;
    repeat (40) @(posedge core_clk);
    rx_stall <= 1'b0;
    next_span(6'h01, 1'b0);
    repeat (500) @(posedge core_clk);
    payload_fault <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp_bit("prot_active", 1'b1, prot_active);
    payload_fault <= 1'b0;
    repeat (3) @(posedge core_clk);
    cmp_bit("prot_active", 1'b1, prot_active);
    next_span(6'h21, 1'b1);
    repeat (3) @(posedge core_clk);
    cmp_bit("prot_active", 1'b0, prot_active);
    next_span(6'h01, 1'b0);
    repeat (3) @(posedge core_clk);
    cmp_bit("prot_active", 1'b1, prot_active);
    next_span(6'h01, 1'b1);
    repeat (3) @(posedge core_clk);
    cmp_bit("prot_active", 1'b0, prot_active);
    next_span(6'h01, 1'b0);
    wait_take();
    repeat (20) @(posedge core_clk);
    cmp_bit("queue empty", 1'b1, rq.size() == 0);
    cmp_bit("protective differs", 1'b1, n_diff > 0);
    end_sim();
  end
endmodule : tb
